// ---- src/pcl_pkg.sv ----
// pcl_pkg: constants, types and the built-in start-up configuration of
// the power control logic.
// assumes a single 100 MHz clock; used by pcl_power_control and its leaf.
package pcl_pkg;

    // ==========================================================
    // clock and timing
    // ==========================================================
    localparam int CLK_MHZ = 100;                  // core clock rate in MHz
    localparam int STEP_TIME_US = 1000;            // 1.0 ms between sequence steps
    localparam int RELEASE_TIME_US = 2000;         // 2.0 ms reset-release delay
    localparam int STEP_CYCLES_DEF = STEP_TIME_US * CLK_MHZ;
    localparam int RELEASE_CYCLES_DEF = RELEASE_TIME_US * CLK_MHZ;
    localparam int TMR_W = 20;                     // holds either count
    localparam int SYNC_STAGES = 2;                // pin synchroniser depth

    // ==========================================================
    // rails, faults and field widths
    // ==========================================================
    localparam int NUM_RAILS = 10;                 // 4 bucks, 5 linear, ddr reference
    localparam int NUM_BUCKS = 4;
    localparam int NUM_FAULTS = 8;
    localparam int SLOT_W = 4;
    localparam int VOLT_W = 8;
    localparam int RAIL_IDX_W = 4;
    localparam logic [RAIL_IDX_W-1:0] RAIL_COUNT = RAIL_IDX_W'(NUM_RAILS);

    // rail indices
    localparam int RAIL_BUCK_ONE = 0;
    localparam int RAIL_BUCK_THREE = 2;
    localparam int RAIL_LDO_FIRST = 4;
    localparam int RAIL_DDR_REF = 9;

    localparam logic [SLOT_W-1:0] SLOT_OFF = 4'h0;        // rail stays off
    localparam logic [SLOT_W-1:0] SLOT_FIRST = 4'h1;      // first sequence step
    localparam logic [NUM_RAILS-1:0] SLEEP_RAILS = 10'h004; // buck three only
    localparam logic [NUM_BUCKS-1:0] PFM_ALL = 4'hf;
    localparam logic [NUM_BUCKS-1:0] PFM_SLEEP = 4'h4;    // buck three only
    localparam logic [NUM_BUCKS-1:0] PFM_NONE = 4'h0;

    // ==========================================================
    // types
    // ==========================================================
    typedef enum logic [2:0] {
        ST_OFF     = 3'b000,
        ST_LOAD    = 3'b001,
        ST_SEQ     = 3'b010,
        ST_DELAY   = 3'b011,
        ST_ON      = 3'b100,
        ST_STANDBY = 3'b101,
        ST_SLEEP   = 3'b110
    } pcl_state_type;

    typedef struct packed {
        logic [SLOT_W-1:0] slot;                   // sequence step, 0 = off
        logic [VOLT_W-1:0] volt;                   // output voltage code
    } pcl_rail_cfg_type;

    typedef pcl_rail_cfg_type [NUM_RAILS-1:0] pcl_cfg_array_type;

    // host write into the active voltage or into the retained start-up ram
    typedef struct packed {
        logic valid;
        logic [RAIL_IDX_W-1:0] rail;
        pcl_rail_cfg_type cfg;
    } pcl_cfg_write_type;

    // ==========================================================
    // built-in start-up configuration, index 9 down to 0:
    // ddr ref, ldo5..ldo1, buck4..buck1 as {slot, volt code}
    // ==========================================================
    localparam pcl_cfg_array_type DEFAULT_CFG = {
        12'h300, 12'h100, 12'h100, 12'h100, 12'h100,
        12'h400, 12'h300, 12'h300, 12'h200, 12'h100
    };

endpackage : pcl_pkg

// ---- src/pcl_sync.sv ----
// pcl_sync: two-flop synchroniser for one asynchronous pin.
// assumes the pin is a slow level; no glitch filtering is done here.
`timescale 1ns/100ps
`default_nettype none

module pcl_sync (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic async_i,
    output logic sync_o
);

    // ==========================================================
    // synchroniser chain
    // ==========================================================
    logic [pcl_pkg::SYNC_STAGES-1:0] chain_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            chain_r <= '0;
        end else begin
            chain_r <= {chain_r[pcl_pkg::SYNC_STAGES-2:0], async_i};
        end
    end

    assign sync_o = chain_r[pcl_pkg::SYNC_STAGES-1];

endmodule : pcl_sync
`default_nettype wire

// ---- src/pcl_power_control.sv ----
// pcl_power_control: power control logic of a multi-output regulator.
// assumes reset_i is the power-on reset from a valid input supply, and
// that fault events, masks and host writes come from logic on clk_i.
`timescale 1ns/100ps
`default_nettype none

module pcl_power_control #(
    parameter int STEP_CYCLES = pcl_pkg::STEP_CYCLES_DEF,
    parameter int RELEASE_CYCLES = pcl_pkg::RELEASE_CYCLES_DEF
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic turn_on_i,
    input wire logic standby_request_i,
    input wire logic standby_polarity_invert_i,
    input wire logic config_source_select_i,
    input wire logic sleep_on_turn_off_i,
    input wire logic vin_above_uv_i,
    input wire logic [pcl_pkg::NUM_FAULTS-1:0] fault_event_i,
    input wire logic [pcl_pkg::NUM_FAULTS-1:0] fault_mask_i,
    input wire logic [pcl_pkg::NUM_FAULTS-1:0] fault_clear_i,
    input wire pcl_pkg::pcl_cfg_write_type volt_write_i,
    input wire pcl_pkg::pcl_cfg_write_type startup_write_i,
    output logic reset_release_out_o,
    output logic reset_release_out_oe_o,
    output logic fault_irq_out_o,
    output logic fault_irq_out_oe_o,
    output logic [pcl_pkg::NUM_FAULTS-1:0] fault_status_o,
    output logic [pcl_pkg::NUM_RAILS-1:0] rail_enable_o,
    output pcl_pkg::pcl_cfg_array_type rail_config_o,
    output logic [pcl_pkg::NUM_BUCKS-1:0] pulse_frequency_mode_o,
    output logic osc16_enable_o,
    output logic osc32_enable_o,
    output logic turn_on_detect_enable_o,
    output logic power_good_o,
    output pcl_pkg::pcl_state_type state_o
);

    // ==========================================================
    // state record
    // ==========================================================
    typedef struct packed {
        pcl_pkg::pcl_state_type state;
        logic [pcl_pkg::SLOT_W-1:0] step;
        logic [pcl_pkg::TMR_W-1:0] tmr;
        pcl_pkg::pcl_cfg_array_type cfg;           // active rail settings
        pcl_pkg::pcl_cfg_array_type ram;           // retained start-up settings
        logic [pcl_pkg::NUM_RAILS-1:0] rail_en;
        logic [pcl_pkg::NUM_FAULTS-1:0] fault_sts;
        logic irq_drv;                             // pull irq pin low
        logic rst_drv;                             // pull reset pin low
    } pcl_regs_type;

    localparam logic [pcl_pkg::TMR_W-1:0] STEP_LAST = pcl_pkg::TMR_W'(STEP_CYCLES - 1);
    localparam logic [pcl_pkg::TMR_W-1:0] RELEASE_LAST =
        pcl_pkg::TMR_W'(RELEASE_CYCLES - 1);

    pcl_regs_type r;
    pcl_regs_type r_nxt;
    logic turn_on_sync;
    logic standby_sync;
    logic standby_active;
    logic running;
    logic [pcl_pkg::SLOT_W-1:0] last_slot;

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    pcl_sync u_sync_turn_on (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i(turn_on_i),
        .sync_o(turn_on_sync)
    );

    pcl_sync u_sync_standby (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i(standby_request_i),
        .sync_o(standby_sync)
    );

    // ==========================================================
    // helpers
    // ==========================================================
    // highest nonzero slot of a configuration, zero when all rails stay off
    function automatic logic [pcl_pkg::SLOT_W-1:0] max_slot(
        input pcl_pkg::pcl_cfg_array_type c
    );
        logic [pcl_pkg::SLOT_W-1:0] m;
        m = pcl_pkg::SLOT_OFF;
        for (int i = 0; i < pcl_pkg::NUM_RAILS; i++) begin
            if (c[i].slot > m) begin
                m = c[i].slot;
            end
        end
        return m;
    endfunction : max_slot

    // standby level after polarity selection
    assign standby_active = standby_sync ^ standby_polarity_invert_i;
    assign last_slot = max_slot(r.cfg);

    // states in which the rails are up or coming up
    assign running = (r.state == pcl_pkg::ST_SEQ) || (r.state == pcl_pkg::ST_DELAY) ||
                     (r.state == pcl_pkg::ST_ON) || (r.state == pcl_pkg::ST_STANDBY);

    // ==========================================================
    // next-state logic
    // ==========================================================
    always_comb begin
        r_nxt = r;

        // sticky faults: a new event wins over a clear in the same cycle
        r_nxt.fault_sts = (r.fault_sts & ~fault_clear_i) | fault_event_i;
        r_nxt.irq_drv = |(r_nxt.fault_sts & ~fault_mask_i);

        // retained start-up settings may be rewritten at any time
        if (startup_write_i.valid && (startup_write_i.rail < pcl_pkg::RAIL_COUNT)) begin
            r_nxt.ram[startup_write_i.rail] = startup_write_i.cfg;
        end

        case (r.state)
            pcl_pkg::ST_OFF,
            pcl_pkg::ST_SLEEP: begin
                r_nxt.rst_drv = 1'b1;
                if (turn_on_sync && vin_above_uv_i) begin
                    r_nxt.state = pcl_pkg::ST_LOAD;
                end
            end
            pcl_pkg::ST_LOAD: begin
                // pick the start-up source, built-in unless ram is selected
                if (config_source_select_i) begin
                    r_nxt.cfg = r.ram;
                end else begin
                    r_nxt.cfg = pcl_pkg::DEFAULT_CFG;
                end
                r_nxt.rail_en = '0;
                r_nxt.step = pcl_pkg::SLOT_FIRST;
                r_nxt.tmr = '0;
                r_nxt.state = pcl_pkg::ST_SEQ;
            end
            pcl_pkg::ST_SEQ: begin
                // at the start of each step, enable rails whose slot matches
                if (r.tmr == '0) begin
                    for (int i = 0; i < pcl_pkg::NUM_RAILS; i++) begin
                        if (r.cfg[i].slot == r.step) begin
                            r_nxt.rail_en[i] = 1'b1;
                        end
                    end
                end
                if ((r.tmr == '0) && (r.step >= last_slot)) begin
                    r_nxt.tmr = '0;
                    r_nxt.state = pcl_pkg::ST_DELAY;
                end else if (r.tmr == STEP_LAST) begin
                    r_nxt.tmr = '0;
                    r_nxt.step = r.step + pcl_pkg::SLOT_FIRST;
                end else begin
                    r_nxt.tmr = r.tmr + pcl_pkg::TMR_W'(1);
                end
            end
            pcl_pkg::ST_DELAY: begin
                // hold reset low for the release delay after the last rail
                if (r.tmr == RELEASE_LAST) begin
                    r_nxt.rst_drv = 1'b0;
                    r_nxt.state = pcl_pkg::ST_ON;
                end else begin
                    r_nxt.tmr = r.tmr + pcl_pkg::TMR_W'(1);
                end
            end
            pcl_pkg::ST_ON: begin
                if (standby_active) begin
                    r_nxt.state = pcl_pkg::ST_STANDBY;
                end
            end
            pcl_pkg::ST_STANDBY: begin
                if (!standby_active) begin
                    r_nxt.state = pcl_pkg::ST_ON;
                end
            end
            default: begin
                r_nxt.state = pcl_pkg::ST_OFF;
            end
        endcase

        // turn-off: the only way reset is pulled low again once released
        if (running && !turn_on_sync) begin
            r_nxt.rst_drv = 1'b1;
            if (sleep_on_turn_off_i) begin
                r_nxt.state = pcl_pkg::ST_SLEEP;
                r_nxt.rail_en = pcl_pkg::SLEEP_RAILS;
            end else begin
                r_nxt.state = pcl_pkg::ST_OFF;
                r_nxt.rail_en = '0;
            end
        end

        // host voltage changes only once power-up has completed
        if (((r.state == pcl_pkg::ST_ON) || (r.state == pcl_pkg::ST_STANDBY)) &&
            volt_write_i.valid && (volt_write_i.rail < pcl_pkg::RAIL_COUNT)) begin
            r_nxt.cfg[volt_write_i.rail].volt = volt_write_i.cfg.volt;
        end
    end

    // ==========================================================
    // state register; power-on reset clears every setting
    // ==========================================================
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            r <= '{state: pcl_pkg::ST_OFF, rst_drv: 1'b1, default: '0};
        end else begin
            r <= r_nxt;
        end
    end

    // ==========================================================
    // open-drain pins: output level low, enable high while pulling
    // ==========================================================
    assign reset_release_out_o = 1'b0;
    assign reset_release_out_oe_o = r.rst_drv;
    assign fault_irq_out_o = 1'b0;
    assign fault_irq_out_oe_o = r.irq_drv;
    assign fault_status_o = r.fault_sts;

    // ==========================================================
    // rail controls and low-power block selection
    // ==========================================================
    assign rail_enable_o = r.rail_en;
    assign rail_config_o = r.cfg;
    assign power_good_o = !r.rst_drv;
    assign state_o = r.state;

    // pulse-frequency mode per buck
    always_comb begin
        case (r.state)
            pcl_pkg::ST_STANDBY: pulse_frequency_mode_o = pcl_pkg::PFM_ALL;
            pcl_pkg::ST_SLEEP: pulse_frequency_mode_o = pcl_pkg::PFM_SLEEP;
            default: pulse_frequency_mode_o = pcl_pkg::PFM_NONE;
        endcase
    end

    // fast oscillator off in off and sleep, slow one always runs
    assign osc16_enable_o = (r.state != pcl_pkg::ST_OFF) &&
                            (r.state != pcl_pkg::ST_SLEEP);
    assign osc32_enable_o = 1'b1;
    assign turn_on_detect_enable_o = ((r.state == pcl_pkg::ST_OFF) ||
                                      (r.state == pcl_pkg::ST_SLEEP)) &&
                                     vin_above_uv_i;

endmodule : pcl_power_control
`default_nettype wire

// ---- verification/pcl_power_control_checker.sv ----
// pcl_power_control_checker: port-level timing checks on the power control.
// assumes it is bound into pcl_power_control and shares its release count.
`timescale 1ns/100ps
`default_nettype none

module pcl_power_control_checker #(
    parameter int RELEASE_CYCLES = 6
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic turn_on_i,
    input wire logic standby_request_i,
    input wire logic standby_polarity_invert_i,
    input wire logic [pcl_pkg::NUM_FAULTS-1:0] fault_event_i,
    input wire logic [pcl_pkg::NUM_FAULTS-1:0] fault_mask_i,
    input wire logic [pcl_pkg::NUM_FAULTS-1:0] fault_clear_i,
    input wire pcl_pkg::pcl_cfg_write_type volt_write_i,
    input wire logic reset_release_out_oe_o,
    input wire logic fault_irq_out_oe_o,
    input wire logic [pcl_pkg::NUM_RAILS-1:0] rail_enable_o,
    input wire pcl_pkg::pcl_cfg_array_type rail_config_o,
    input wire logic [pcl_pkg::NUM_BUCKS-1:0] pulse_frequency_mode_o,
    input wire logic osc16_enable_o,
    input wire logic osc32_enable_o,
    input wire pcl_pkg::pcl_state_type state_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // ==========================================================
    // helper: cycles spent in the release delay
    // ==========================================================
    logic [pcl_pkg::TMR_W-1:0] dly_cnt_r;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            dly_cnt_r <= '0;
        end else begin
            dly_cnt_r <= (state_o == pcl_pkg::ST_DELAY) ? dly_cnt_r + 1'b1 : '0;
        end
    end

    // standby pin active for long enough to pass the synchroniser
    sequence standby_request_held;
        (turn_on_i && (standby_request_i ^ standby_polarity_invert_i))[*3];
    endsequence

    // ==========================================================
    // assertions
    // ==========================================================
    a_release_after_delay: assert property (
        $fell(reset_release_out_oe_o) |-> dly_cnt_r == pcl_pkg::TMR_W'(RELEASE_CYCLES)
        && state_o == pcl_pkg::ST_ON) else $error("reset release off its delay");
    a_reset_held_low: assert property (
        state_o inside {pcl_pkg::ST_OFF, pcl_pkg::ST_LOAD, pcl_pkg::ST_SEQ, pcl_pkg::ST_DELAY}
        |-> reset_release_out_oe_o) else $error("reset released too early");
    a_reset_stays_released: assert property (
        state_o inside {pcl_pkg::ST_ON, pcl_pkg::ST_STANDBY} |-> !reset_release_out_oe_o)
        else $error("reset asserted while running");
    a_irq_on_fault: assert property (
        |(fault_event_i & ~fault_mask_i) |=> fault_irq_out_oe_o) else $error("irq missed");
    a_irq_held_clear: assert property (
        $fell(fault_irq_out_oe_o) |-> $past(|fault_clear_i)
        || ($past(fault_mask_i, 2) != $past(fault_mask_i))) else $error("irq dropped alone");
    a_standby_entry: assert property (
        (standby_request_held ##0 state_o == pcl_pkg::ST_ON) |=> state_o == pcl_pkg::ST_STANDBY)
        else $error("standby not entered");
    a_standby_modes: assert property (
        state_o == pcl_pkg::ST_STANDBY |-> pulse_frequency_mode_o == pcl_pkg::PFM_ALL
        && osc16_enable_o) else $error("standby mode wrong");
    a_sleep_modes: assert property (
        state_o == pcl_pkg::ST_SLEEP |-> pulse_frequency_mode_o == pcl_pkg::PFM_SLEEP
        && !osc16_enable_o && rail_enable_o == pcl_pkg::SLEEP_RAILS) else $error("sleep wrong");
    a_off_modes: assert property (
        state_o == pcl_pkg::ST_OFF |-> rail_enable_o == '0 && !osc16_enable_o
        && osc32_enable_o && pulse_frequency_mode_o == '0) else $error("off mode wrong");
    a_volt_write_taken: assert property (
        state_o == pcl_pkg::ST_ON && volt_write_i.valid && volt_write_i.rail < pcl_pkg::RAIL_COUNT
        |=> rail_config_o[$past(volt_write_i.rail)].volt == $past(volt_write_i.cfg.volt))
        else $error("voltage write lost");
endmodule : pcl_power_control_checker

bind pcl_power_control pcl_power_control_checker #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_chk (
    .clk_i(clk_i), .reset_i(reset_i), .turn_on_i(turn_on_i),
    .standby_request_i(standby_request_i), .standby_polarity_invert_i(standby_polarity_invert_i),
    .fault_event_i(fault_event_i), .fault_mask_i(fault_mask_i), .fault_clear_i(fault_clear_i),
    .volt_write_i(volt_write_i), .reset_release_out_oe_o(reset_release_out_oe_o),
    .fault_irq_out_oe_o(fault_irq_out_oe_o), .rail_enable_o(rail_enable_o),
    .rail_config_o(rail_config_o), .pulse_frequency_mode_o(pulse_frequency_mode_o),
    .osc16_enable_o(osc16_enable_o), .osc32_enable_o(osc32_enable_o), .state_o(state_o));
`default_nettype wire

// ---- verification/pcl_host_model.sv ----
// pcl_host_model: host processor on the reset and interrupt pins.
// assumes pull-ups on both open-drain pins and the block's clock.
`timescale 1ns/100ps
`default_nettype none

module pcl_host_model (
    input wire logic clk_i,
    input wire logic reset_release_out_oe_i,
    input wire logic fault_irq_out_oe_i,
    input wire logic service_enable_i,
    input wire logic [pcl_pkg::NUM_FAULTS-1:0] fault_status_i,
    output logic reset_n_pin_o,
    output logic irq_n_pin_o,
    output logic [pcl_pkg::NUM_FAULTS-1:0] fault_clear_o
);
    // pull-ups set the pin level whenever the block lets go
    assign reset_n_pin_o = !reset_release_out_oe_i;
    assign irq_n_pin_o = !fault_irq_out_oe_i;

    // service routine: one write-one pulse of the status it read back
    initial begin
        fault_clear_o = '0;
        forever begin
            @(negedge clk_i);
            if (service_enable_i && !irq_n_pin_o && fault_clear_o == '0) begin
                fault_clear_o = fault_status_i;
            end else begin
                fault_clear_o = '0;
            end
        end
    end
endmodule : pcl_host_model
`default_nettype wire

// ---- verification/pcl_power_control_tb.sv ----
// pcl_power_control_tb: directed sequences through power-up, modes and faults.
// assumes shortened step and release counts; inputs change on falling edges.
`timescale 1ns/100ps
`default_nettype none

module pcl_power_control_tb;
    localparam int STEP = 4;
    localparam int REL = 6;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic turn_on = 1'b0, standby_request = 1'b0, inv = 1'b0, src = 1'b0, sleep = 1'b0, vin = 1'b0, svc = 1'b0;
    logic [pcl_pkg::NUM_FAULTS-1:0] f_ev = '0, f_mask = '0, f_clr, f_stat;
    pcl_pkg::pcl_cfg_write_type vw = '0, sw = '0;
    logic rst_oe, irq_oe, rst_n, irq_n, osc16, osc32, det, pg, unused_rst, unused_irq;
    logic [pcl_pkg::NUM_RAILS-1:0] rails;
    pcl_pkg::pcl_cfg_array_type cfg;
    logic [pcl_pkg::NUM_BUCKS-1:0] pulse_frequency_mode;
    pcl_pkg::pcl_state_type st;
    int miscompares = 0, num_checks = 0, cycles = 0;

    pcl_power_control #(.STEP_CYCLES(STEP), .RELEASE_CYCLES(REL)) dut (
        .clk_i(clk_i), .reset_i(reset_i), .turn_on_i(turn_on), .standby_request_i(standby_request),
        .standby_polarity_invert_i(inv), .config_source_select_i(src),
        .sleep_on_turn_off_i(sleep), .vin_above_uv_i(vin), .fault_event_i(f_ev),
        .fault_mask_i(f_mask), .fault_clear_i(f_clr), .volt_write_i(vw), .startup_write_i(sw),
        .reset_release_out_o(unused_rst), .reset_release_out_oe_o(rst_oe),
        .fault_irq_out_o(unused_irq), .fault_irq_out_oe_o(irq_oe), .fault_status_o(f_stat),
        .rail_enable_o(rails), .rail_config_o(cfg), .pulse_frequency_mode_o(pulse_frequency_mode),
        .osc16_enable_o(osc16), .osc32_enable_o(osc32), .turn_on_detect_enable_o(det),
        .power_good_o(pg), .state_o(st));
    pcl_host_model u_host (.clk_i(clk_i), .reset_release_out_oe_i(rst_oe),
        .fault_irq_out_oe_i(irq_oe), .service_enable_i(svc), .fault_status_i(f_stat),
        .reset_n_pin_o(rst_n), .irq_n_pin_o(irq_n), .fault_clear_o(f_clr));

    // ==========================================================
    // clock, timeout and shared tasks
    // ==========================================================
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one-cycle write of {slot, volt} to the active set or the start-up ram
    task automatic wr(input logic ram, input logic [3:0] r, input logic [11:0] c);
        @(negedge clk_i);
        sw = ram ? {1'b1, r, c} : '0;
        vw = ram ? '0 : {1'b1, r, c};
        @(negedge clk_i);
        sw = '0;
        vw = '0;
    endtask : wr

    task automatic wait_st(input pcl_pkg::pcl_state_type s);
        int n;
        n = 0;
        while (st !== s && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        chk(st, s);
    endtask : wait_st

    // power up and log when each rail comes on
    task automatic power_up(input pcl_pkg::pcl_cfg_array_type exp);
        int n, last, base;
        int on_at [pcl_pkg::NUM_RAILS];
        n = 0;
        last = 0;
        base = 0;
        on_at = '{default: -1};
        turn_on = 1'b1;
        while (st !== pcl_pkg::ST_ON && n < 300) begin
            @(negedge clk_i);
            n++;
            for (int i = 0; i < pcl_pkg::NUM_RAILS; i++) begin
                if (rails[i] === 1'b1 && on_at[i] < 0) begin
                    on_at[i] = n;
                    last = n;
                end
            end
        end
        chk({st, rst_n, pg, unused_rst, unused_irq, cfg}, {pcl_pkg::ST_ON, 2'h3, 2'h0, exp});
        chk(n - last, REL);
        for (int i = 0; i < pcl_pkg::NUM_RAILS; i++) begin
            if (exp[i].slot == pcl_pkg::SLOT_FIRST) base = on_at[i];
        end
        for (int i = 0; i < pcl_pkg::NUM_RAILS; i++) begin
            chk(on_at[i], exp[i].slot == '0 ? -1 : base + (int'(exp[i].slot) - 1) * STEP);
        end
    endtask : power_up

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        pcl_pkg::pcl_cfg_array_type e;
        repeat (6) @(negedge clk_i);
        reset_i = 1'b0;
        chk({st, rst_n, irq_n, rails, osc16, osc32}, {pcl_pkg::ST_OFF, 2'h1, 10'h000, 2'h1});
        turn_on = 1'b1;
        repeat (10) @(negedge clk_i);
        chk(st, pcl_pkg::ST_OFF);
        vin = 1'b1;
        power_up(pcl_pkg::DEFAULT_CFG);
        // standby entry and exit through both polarities
        for (int k = 0; k < 4; k++) begin
            standby_request = (k == 0) || (k == 3);
            inv = (k >= 2);
            repeat (4) @(negedge clk_i);
            chk({st, pulse_frequency_mode, rails}, k[0] ? {pcl_pkg::ST_ON, 14'h03ff} : {pcl_pkg::ST_STANDBY, 14'h3fff});
        end
        e = pcl_pkg::DEFAULT_CFG;
        e[2].volt = 8'h5a;
        wr(1'b0, 4'h2, 12'h05a);
        wr(1'b0, 4'ha, 12'h0ff);
        chk(cfg, e);
        // masked fault sets status only; unmasked holds irq until cleared
        f_mask = 8'h01;
        f_ev = 8'h01;
        @(negedge clk_i);
        f_ev = 8'h04;
        @(negedge clk_i);
        f_ev = 8'h00;
        repeat (5) @(negedge clk_i);
        chk({irq_n, f_stat}, {1'b0, 8'h05});
        svc = 1'b1;
        repeat (4) @(negedge clk_i);
        chk({irq_n, f_stat}, {1'b1, 8'h00});
        svc = 1'b0;
        wr(1'b1, 4'h0, 12'h044);
        wr(1'b1, 4'h1, 12'h133);
        wr(1'b1, 4'h2, 12'h1a0);
        turn_on = 1'b0;
        wait_st(pcl_pkg::ST_OFF);
        chk({rst_n, rails, osc16, osc32, det, pulse_frequency_mode}, {1'b0, 10'h000, 3'h3, 4'h0});
        e = '0;
        e[0] = 12'h044;
        e[1] = 12'h133;
        e[2] = 12'h1a0;
        src = 1'b1;
        power_up(e);
        sleep = 1'b1;
        turn_on = 1'b0;
        wait_st(pcl_pkg::ST_SLEEP);
        chk({rails, pulse_frequency_mode, osc16, rst_n}, {pcl_pkg::SLEEP_RAILS, pcl_pkg::PFM_SLEEP, 2'h0});
        conclude();
    end
endmodule : pcl_power_control_tb
`default_nettype wire
